// >>> abc_clock_config.sv
// Purpose: Clock, boot and stream configuration control of the audio bridge.
// Assumes: Register port and gear/rate inputs are on i_mclk; button is a pin.
// Notes:   Clock multiplexers themselves sit outside; this drives their enables.
//
// The address-and-strobe port and the register addresses were decided locally.
`default_nettype none

// How it works
// - Framer boots inactive or primary from the applied boot setting.
// - Framer clock picks 12MHz-referenced synth or external clock input.
// - Applied root code programs framer synth and framing information.
// - Codes 1..9 map to nominal frequencies; code 0 means not indicated.
// - Synth for code 2 targets 22.578998 MHz; others exactly nominal.
// - Bus-holder on data line enabled or disabled by configuration.
// - Bus IO level selects 1.8V or 1.2V.
// - Instance value is 0 or 1 for two bridges on one bus.
// - Three bus-writable value elements drive bridge functions.
// - Button held four seconds then released reboots and hard-resets bus.
// - Boot mode, root code, instance apply only at long-press reboot; status shows applied.
// - Knob press while bus clock paused drives the data line high for 1 us.
// - Input master clock from synth, input connector or coax.
// - Output master clock from synth, output connector or coax.
// - Selected master clock of each side driven on buffered output.
// - Rate converters on digital and serial input, each with own enable.
// - Fed master clock runs at 128 or 256 times sample rate.
// - Synth-sourced output clocks derive from bus clock, no converter.
// - Streaming refused while bus gear below synth reference gear.
// - Differing reference gears: never both synths; flag error.
// - Outputs play one of four streams, each a port pair.
module abc_clock_config #(
  parameter int unsigned LONG_PRESS_CYCLES = abc_pkg::LONG_PRESS_CYC
) (
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_srst,
  // Register port
  input  wire logic [7:0]            i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [31:0]           o_rdata,
  // Front panel and bus core status
  input  wire logic                  i_button,
  input  wire logic                  i_bus_clk_paused,
  input  wire logic [3:0]            i_bus_clock_gear,
  input  wire logic [3:0]            i_in_ref_gear,
  input  wire logic [3:0]            i_out_ref_gear,
  input  wire logic                  i_in_rate_high,
  // Framer and bus interface setup
  output logic                       o_framer_primary,
  output logic                       o_framer_clk_ext,
  output logic                       o_framer_synth_en,
  output logic      [24:0]           o_framer_synth_hz,
  output logic      [3:0]            o_root_freq_code,
  output logic                       o_instance_value,
  output logic                       o_bus_holder_en,
  output logic                       o_io_level_1v2,
  output logic                       o_ctrl_reboot,
  output logic                       o_bus_hard_rst,
  // Bus data line wake drive
  output logic                       o_data_out,
  output logic                       o_data_oe,
  // Master clock muxes and buffers
  output abc_pkg::abc_mclk_en_t      o_in_mclk_en,
  output abc_pkg::abc_mclk_en_t      o_out_mclk_en,
  output logic                       o_in_mclk_buf_en,
  output logic                       o_out_mclk_buf_en,
  output logic                       o_in_mclk_128fs,
  // Audio path setup
  output logic                       o_rate_converter_dsi_en,
  output logic                       o_rate_converter_spdif_en,
  output logic                       o_out_from_bus_clk,
  output logic                       o_stream_ok,
  output logic                       o_synth_conflict,
  output logic      [1:0]            o_stream_sel,
  output logic      [2:0]            o_stream_port_lo,
  output logic      [23:0]           o_value_element
);

  // ------------------------------------------------------------------------
  // Types and state
  // ------------------------------------------------------------------------
  typedef enum logic [1:0] {BTN_IDLE, BTN_SHORT, BTN_LONG} abc_btn_t;

  typedef struct packed {
    logic [31:0]           rdata;
    logic [8:0]            boot_pend;
    logic [7:0]            audio_cfg;
    logic [23:0]           values;
    abc_pkg::abc_boot_t    boot;
    logic [1:0]            btn_sync;
    abc_btn_t              btn;
    logic [31:0]           held;
    logic                  reboot;
    logic [15:0]           wake_cnt;
    logic [1:0]            in_src;
    logic [1:0]            out_src;
    logic [7:0]            in_gap;
    logic [7:0]            out_gap;
    abc_pkg::abc_mclk_en_t in_en;
    abc_pkg::abc_mclk_en_t out_en;
    logic                  stream_ok;
    logic                  conflict;
    logic                  rate128;
    logic [24:0]           synth_hz;
    logic                  synth_en;
    logic [1:0]            buf_en;
    logic                  data_oe;
    logic [2:0]            port_lo;
  } abc_state_t;

  abc_state_t s_q;
  abc_state_t s_d;

  // ------------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------------
  // nominal root frequency in Hz; zero for not indicated
  function automatic logic [24:0] rf_nominal_hz(input logic [3:0] code);
    unique case (code)
      4'h1:    rf_nominal_hz = 25'h1770000;
      4'h2:    rf_nominal_hz = 25'h1588800;
      4'h3:    rf_nominal_hz = 25'h0EA6000;
      4'h4:    rf_nominal_hz = 25'h1005900;
      4'h5:    rf_nominal_hz = 25'h124F800;
      4'h6:    rf_nominal_hz = 25'h16E3600;
      4'h7:    rf_nominal_hz = 25'h17D7840;
      4'h8:    rf_nominal_hz = 25'h18CBA80;
      4'h9:    rf_nominal_hz = 25'h19BFCC0;
      default: rf_nominal_hz = 25'h0000000;
    endcase
  endfunction : rf_nominal_hz

  // One-hot enable for a source code
  function automatic abc_pkg::abc_mclk_en_t src_onehot(input logic [1:0] src);
    src_onehot.synth = (src == abc_pkg::SRC_SYNTH);
    src_onehot.conn  = (src == abc_pkg::SRC_CONN);
    src_onehot.coax  = (src == abc_pkg::SRC_COAX);
  endfunction : src_onehot

  // Source field with illegal code folded onto the synth
  function automatic logic [1:0] src_legal(input logic [1:0] src);
    src_legal = (src == 2'h3) ? abc_pkg::SRC_SYNTH : src;
  endfunction : src_legal

  // ------------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------------
  logic [1:0] want_in;
  logic [1:0] want_out;
  logic       both_synth;
  logic       any_synth;
  logic [3:0] ref_gear;

  always_comb begin
    s_d       = s_q;
    s_d.rdata = 32'h00000000;
    want_in   = src_legal(s_q.audio_cfg[abc_pkg::AC_IN_LSB +: 2]);
    want_out  = src_legal(s_q.audio_cfg[abc_pkg::AC_OUT_LSB +: 2]);

    // Register writes
    if (i_wr) begin
      unique case (i_addr)
        abc_pkg::OFS_BOOT_CFG:  s_d.boot_pend = i_wdata[8:0];
        abc_pkg::OFS_AUDIO_CFG: s_d.audio_cfg = i_wdata[7:0];
        abc_pkg::OFS_VALUE0:    s_d.values[7:0]   = i_wdata[7:0];
        abc_pkg::OFS_VALUE1:    s_d.values[15:8]  = i_wdata[7:0];
        abc_pkg::OFS_VALUE2:    s_d.values[23:16] = i_wdata[7:0];
        default: ;
      endcase
    end
    s_d.port_lo = {s_d.audio_cfg[abc_pkg::AC_STRM_LSB +: 2], 1'b0};

    // Register reads, data in the following cycle; unmapped read as zero
    if (i_rd) begin
      unique case (i_addr)
        abc_pkg::OFS_BOOT_CFG:  s_d.rdata = {23'h000000, s_q.boot_pend};
        abc_pkg::OFS_AUDIO_CFG: s_d.rdata = {24'h000000, s_q.audio_cfg};
        abc_pkg::OFS_VALUE0:    s_d.rdata = {24'h000000, s_q.values[7:0]};
        abc_pkg::OFS_VALUE1:    s_d.rdata = {24'h000000, s_q.values[15:8]};
        abc_pkg::OFS_VALUE2:    s_d.rdata = {24'h000000, s_q.values[23:16]};
        abc_pkg::OFS_STATUS:    s_d.rdata = {23'h000000, s_q.conflict, s_q.stream_ok,
                                             s_q.boot.inst, s_q.boot.rf,
                                             s_q.boot.clk_ext, s_q.boot.primary};
        abc_pkg::OFS_ID:        s_d.rdata = {16'h0000, abc_pkg::ID_VALUE};
        default:                s_d.rdata = 32'h00000000;
      endcase
    end

    // Button synchroniser; only the second stage is looked at
    s_d.btn_sync = {s_q.btn_sync[0], i_button};
    s_d.reboot   = 1'b0;

    unique case (s_q.btn)
      BTN_IDLE: begin
        s_d.held = 32'h00000000;
        if (s_q.btn_sync[1]) begin
          s_d.btn = BTN_SHORT;
          if (i_bus_clk_paused && s_q.wake_cnt == 16'h0000) begin
            s_d.wake_cnt = 16'(abc_pkg::WAKE_PULSE_CYC);
          end
        end
      end
      BTN_SHORT: begin
        s_d.held = s_q.held + 32'h00000001;
        if (!s_q.btn_sync[1]) begin
          s_d.btn = BTN_IDLE;
        end else if (s_q.held >= 32'(LONG_PRESS_CYCLES - 2)) begin
          s_d.btn = BTN_LONG;
        end
      end
      BTN_LONG: begin
        if (!s_q.btn_sync[1]) begin
          s_d.btn    = BTN_IDLE;
          s_d.reboot = 1'b1;
        end
      end
    endcase

    if (s_q.wake_cnt != 16'h0000) begin
      s_d.wake_cnt = s_q.wake_cnt - 16'h0001;
    end
    s_d.data_oe = (s_d.wake_cnt != 16'h0000);

    // pending boot setup applies only on reboot
    if (s_q.reboot) begin
      s_d.boot.primary = s_q.boot_pend[abc_pkg::BC_PRIMARY];
      s_d.boot.clk_ext = s_q.boot_pend[abc_pkg::BC_CLK_EXT];
      s_d.boot.inst    = s_q.boot_pend[abc_pkg::BC_INST];
      s_d.boot.rf      = (s_q.boot_pend[abc_pkg::BC_RF_LSB +: 4] > abc_pkg::RF_MAX) ?
                         abc_pkg::RF_NONE : s_q.boot_pend[abc_pkg::BC_RF_LSB +: 4];
    end
    // synth target follows the applied code
    s_d.synth_en = !s_d.boot.clk_ext && (s_d.boot.rf != abc_pkg::RF_NONE);
    s_d.synth_hz = (s_d.boot.rf == 4'h2) ? abc_pkg::RF2_SYNTH_HZ : rf_nominal_hz(s_d.boot.rf);

    if (s_q.in_gap != 8'h00) begin
      s_d.in_gap = s_q.in_gap - 8'h01;
      if (s_q.in_gap == 8'h01) begin
        s_d.in_src = want_in;
      end
    end else if (want_in != s_q.in_src) begin
      s_d.in_gap = 8'(abc_pkg::MUX_GAP_CYC);
    end

    if (s_q.out_gap != 8'h00) begin
      s_d.out_gap = s_q.out_gap - 8'h01;
      if (s_q.out_gap == 8'h01) begin
        s_d.out_src = want_out;
      end
    end else if (want_out != s_q.out_src) begin
      s_d.out_gap = 8'(abc_pkg::MUX_GAP_CYC);
    end

    // both synths need matching reference gears
    both_synth   = (s_q.in_src == abc_pkg::SRC_SYNTH) && (s_q.out_src == abc_pkg::SRC_SYNTH);
    s_d.conflict = both_synth && (i_in_ref_gear != i_out_ref_gear);

    // input source enable, idle during the gap
    s_d.in_en = (s_d.in_gap != 8'h00 || s_q.in_gap != 8'h00) ? 3'b000 :
                src_onehot(s_q.in_src);
    // output source enable; output synth held off on conflict
    s_d.out_en = (s_d.out_gap != 8'h00 || s_q.out_gap != 8'h00) ? 3'b000 :
                 src_onehot(s_q.out_src);
    if (s_d.conflict) begin
      s_d.out_en.synth = 1'b0;
    end
    s_d.buf_en = {|s_d.in_en, |s_d.out_en};

    // streaming needs bus gear at or above the reference gear
    any_synth = (s_q.in_src == abc_pkg::SRC_SYNTH) || (s_q.out_src == abc_pkg::SRC_SYNTH);
    ref_gear  = (s_q.in_src == abc_pkg::SRC_SYNTH) ? i_in_ref_gear : i_out_ref_gear;
    if (both_synth && i_out_ref_gear > i_in_ref_gear) begin
      ref_gear = i_out_ref_gear;
    end
    s_d.stream_ok = !s_d.conflict && !(any_synth && i_bus_clock_gear < ref_gear);

    // fed master clock ratio follows the presence rate
    s_d.rate128 = i_in_rate_high;
  end

  // ------------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s_q           <= '0;
      s_q.btn       <= BTN_IDLE;
      s_q.boot_pend <= abc_pkg::BOOT_CFG_RST;
      s_q.audio_cfg <= abc_pkg::AUDIO_CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------------
  // Outputs, all but the tied-high o_data_out straight from the state register
  // ------------------------------------------------------------------------
  // boot behaviour and framer clock source
  assign o_framer_primary   = s_q.boot.primary;
  assign o_framer_clk_ext   = s_q.boot.clk_ext;
  // applied root code, synth and instance; code 0 not synthesised
  assign o_root_freq_code   = s_q.boot.rf;
  assign o_framer_synth_en  = s_q.synth_en;
  assign o_framer_synth_hz  = s_q.synth_hz;
  assign o_instance_value   = s_q.boot.inst;
  // holder and IO level follow the live setting
  assign o_bus_holder_en    = s_q.boot_pend[abc_pkg::BC_HOLDER];
  assign o_io_level_1v2     = s_q.boot_pend[abc_pkg::BC_LVL_1V2];
  assign o_ctrl_reboot      = s_q.reboot;
  assign o_bus_hard_rst     = s_q.reboot;
  assign o_data_out         = 1'b1;
  assign o_data_oe          = s_q.data_oe;
  assign o_in_mclk_en       = s_q.in_en;
  assign o_out_mclk_en      = s_q.out_en;
  // buffered clock outputs follow the live source
  assign o_in_mclk_buf_en   = s_q.buf_en[1];
  assign o_out_mclk_buf_en  = s_q.buf_en[0];
  assign o_in_mclk_128fs    = s_q.rate128;
  assign o_rate_converter_dsi_en      = s_q.audio_cfg[abc_pkg::AC_RATE_CONVERTER_DSI];
  assign o_rate_converter_spdif_en    = s_q.audio_cfg[abc_pkg::AC_RATE_CONVERTER_SPD];
  assign o_out_from_bus_clk = s_q.out_en.synth;
  assign o_stream_ok        = s_q.stream_ok;
  assign o_synth_conflict   = s_q.conflict;
  assign o_stream_sel       = s_q.audio_cfg[abc_pkg::AC_STRM_LSB +: 2];
  assign o_stream_port_lo   = s_q.port_lo;
  assign o_value_element    = s_q.values;
  assign o_rdata            = s_q.rdata;

  // ------------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sequence seq_release_long;
    s_q.btn == BTN_LONG && s_q.btn_sync[1] ##1 !s_q.btn_sync[1];
  endsequence

  AST_REBOOT_ON_RELEASE: assert property (
    seq_release_long |=> o_ctrl_reboot && o_bus_hard_rst)
    else $error("long press release did not reboot");

  AST_BOOT_ONLY_REBOOT: assert property (
    !$past(s_q.reboot) |-> $stable(o_root_freq_code) && $stable(o_framer_primary))
    else $error("boot setup changed without reboot");

  AST_RF2_SYNTH: assert property (
    o_root_freq_code == 4'h2 |-> o_framer_synth_hz == 25'h1588736)
    else $error("code 2 synth frequency wrong");

  AST_NO_OVERLAP_IN: assert property (
    $changed(s_q.in_src) |-> $past(o_in_mclk_en) == 3'b000 && o_in_mclk_en == 3'b000)
    else $error("input clock switched without gap");

  AST_ONEHOT_OUT: assert property (
    $onehot0(o_out_mclk_en))
    else $error("two output clock sources enabled");

  AST_CONFLICT_FLAG: assert property (
    o_synth_conflict |-> !(o_in_mclk_en.synth && o_out_mclk_en.synth) && !o_stream_ok)
    else $error("both synths run on conflict");

  AST_GEAR_REFUSE: assert property (
    (o_in_mclk_en.synth && i_bus_clock_gear < i_in_ref_gear
     && $stable(i_bus_clock_gear) && $stable(i_in_ref_gear)) |=> !o_stream_ok)
    else $error("streaming allowed below reference gear");

  AST_WAKE_PULSE: assert property (
    $rose(o_data_oe) |-> o_data_oe [*8])
    else $error("wake pulse too short");

  AST_WRITE_VALUE: assert property (
    i_wr && i_addr == abc_pkg::OFS_VALUE1 |=> o_value_element[15:8] == $past(i_wdata[7:0]))
    else $error("value element write lost");

  AST_PORT_PAIR: assert property (
    o_stream_port_lo == {o_stream_sel, 1'b0})
    else $error("stream port pair wrong");

endmodule : abc_clock_config

`default_nettype wire

// >>> abc_pkg.sv
// Purpose: Shared constants and carriers for the audio bridge clock config.
// Assumes: 100 MHz i_mclk, synchronous active-high reset.
// Notes:   Register offsets are byte addresses on the plain register port.
`default_nettype none

package abc_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int unsigned LONG_PRESS_S    = 4;
  localparam int unsigned LONG_PRESS_CYC  = LONG_PRESS_S * CLK_HZ;
  localparam int unsigned MUX_GAP_NS      = 200;
  localparam int unsigned MUX_GAP_CYC     = (MUX_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_PULSE_NS   = 1000;
  localparam int unsigned WAKE_PULSE_CYC  = WAKE_PULSE_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_BOOT_CFG  = 8'h00;
  localparam logic [7:0] OFS_AUDIO_CFG = 8'h04;
  localparam logic [7:0] OFS_VALUE0    = 8'h08;
  localparam logic [7:0] OFS_VALUE1    = 8'h0C;
  localparam logic [7:0] OFS_VALUE2    = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_ID        = 8'h18;

  // Boot config fields
  localparam int unsigned BC_PRIMARY   = 0;
  localparam int unsigned BC_CLK_EXT   = 1;
  localparam int unsigned BC_HOLDER    = 2;
  localparam int unsigned BC_LVL_1V2   = 3;
  localparam int unsigned BC_RF_LSB    = 4;
  localparam int unsigned BC_INST      = 8;
  // Audio config fields
  localparam int unsigned AC_IN_LSB    = 0;
  localparam int unsigned AC_OUT_LSB   = 2;
  localparam int unsigned AC_RATE_CONVERTER_DSI  = 4;
  localparam int unsigned AC_RATE_CONVERTER_SPD  = 5;
  localparam int unsigned AC_STRM_LSB  = 6;

  // Reset values
  localparam logic [8:0] BOOT_CFG_RST  = 9'h004;
  localparam logic [7:0] AUDIO_CFG_RST = 8'h00;
  // Arbitrary neutral identity value
  localparam logic [15:0] ID_VALUE     = 16'hA5C3;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] SRC_SYNTH = 2'h0;
  localparam logic [1:0] SRC_CONN  = 2'h1;
  localparam logic [1:0] SRC_COAX  = 2'h2;
  localparam logic [3:0] RF_NONE   = 4'h0;
  localparam logic [3:0] RF_MAX    = 4'h9;
  localparam logic [24:0] RF2_SYNTH_HZ = 25'h1588736;

  // Applied framer setup, taken from the pending copy only at reboot
  typedef struct packed {
    logic       primary;
    logic       clk_ext;
    logic [3:0] rf;
    logic       inst;
  } abc_boot_t;

  // One-hot master clock source enables
  typedef struct packed {
    logic synth;
    logic conn;
    logic coax;
  } abc_mclk_en_t;

endpackage : abc_pkg

`default_nettype wire

// >>> abc_far_model.sv
// Purpose: Far side model: bus core gear and serial audio clock master.
// Assumes: Commands come from the bench on the bench clock.
// Notes:   Ratio flag follows the presence rate given in kHz.
`default_nettype none
module abc_far_model (
  // Clock
  input  wire logic       i_mclk,
  // Commands from the bench
  input  wire logic [7:0] i_rate_khz,
  input  wire logic [3:0] i_gear,
  // Toward the block
  output logic            o_rate_high,
  output logic [3:0]      o_bus_gear
);
  timeunit 1ns;
  timeprecision 1ps;
  // Known levels before the first edge
  initial begin
    o_rate_high = 1'b0;
    o_bus_gear  = 4'h9;
  end
  always @(posedge i_mclk) begin
    o_rate_high <= (i_rate_khz >= 8'h80);
    o_bus_gear  <= i_gear;
  end
endmodule : abc_far_model
`default_nettype wire

// >>> abc_clock_config_tb_top.sv
// Purpose: Self-checking bench of the clock and boot configuration block.
// Assumes: Long press shortened to LP cycles so reboots stay quick.
// Notes:   Reads are checked from a queue by a separate watcher.
`default_nettype none
module abc_clock_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LP = 50;
  localparam logic [24:0] HZ [10] = '{25'h0, 25'h1770000, 25'h1588736, 25'h0EA6000,
    25'h1005900, 25'h124F800, 25'h16E3600, 25'h17D7840, 25'h18CBA80, 25'h19BFCC0};
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, btn = 1'b0, paused = 1'b0;
  logic        rd_s = 1'b0, rhigh;
  logic [7:0]  addr = 8'h00, rate = 8'h30;
  logic [31:0] wdata = 32'h0, rdata, x = 32'h1F;
  logic [3:0]  gear = 4'h9, iref = 4'h6, oref = 4'h6, bgear, code, prev;
  logic [24:0] hz;
  logic [23:0] ve, vexp;
  logic [2:0]  plo;
  logic [1:0]  sel;
  logic        prim, cext, sen, inst, hold, lvl, oe, ibuf, obuf, f128, adsi, aspd, fbus;
  logic        sok, conf, rbt, hrst, dout;
  logic [31:0] n_rbt = 32'h0;
  abc_pkg::abc_mclk_en_t ien, oen;
  int          mismatches = 0, n_checks = 0, cyc = 0;
  logic [31:0] expq [$];

  // Clock at 100 MHz
  initial begin
    forever #5 clk = ~clk;
  end

  abc_far_model far_u (.i_mclk(clk), .i_rate_khz(rate), .i_gear(gear), .o_rate_high(rhigh),
    .o_bus_gear(bgear));

  abc_clock_config #(.LONG_PRESS_CYCLES(LP)) dut_u (.i_mclk(clk), .i_srst(srst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_button(btn),
    .i_bus_clk_paused(paused), .i_bus_clock_gear(bgear), .i_in_ref_gear(iref),
    .i_out_ref_gear(oref), .i_in_rate_high(rhigh), .o_framer_primary(prim),
    .o_framer_clk_ext(cext), .o_framer_synth_en(sen), .o_framer_synth_hz(hz),
    .o_root_freq_code(code), .o_instance_value(inst), .o_bus_holder_en(hold),
    .o_io_level_1v2(lvl), .o_ctrl_reboot(rbt), .o_bus_hard_rst(hrst), .o_data_out(dout),
    .o_data_oe(oe), .o_in_mclk_en(ien), .o_out_mclk_en(oen), .o_in_mclk_buf_en(ibuf),
    .o_out_mclk_buf_en(obuf), .o_in_mclk_128fs(f128), .o_rate_converter_dsi_en(adsi),
    .o_rate_converter_spdif_en(aspd), .o_out_from_bus_clk(fbus), .o_stream_ok(sok),
    .o_synth_conflict(conf), .o_stream_sel(sel), .o_stream_port_lo(plo),
    .o_value_element(ve));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg

  // Expected data noted now, compared by the watcher
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd   <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rreg

  task automatic press(input int n);
    btn <= 1'b1;
    repeat (n) @(posedge clk);
    btn <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : press

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) rd_s <= rd;
  always @(negedge clk) begin
    if (rd_s) chk("o_rdata", expq.pop_front(), rdata);
  end

  // Reboot and bus reset pulses, one count per high cycle of each
  always @(negedge clk) begin
    if (!srst) n_rbt <= n_rbt + rbt + hrst;
  end

  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rreg(abc_pkg::OFS_BOOT_CFG, 32'h4);
    rreg(abc_pkg::OFS_ID, {16'h0, abc_pkg::ID_VALUE});
    rreg(8'h1C, 32'h0);
    $display("test reset done");
    prev = 4'h0;
    for (int c = 0; c < 11; c++) begin
      wreg(abc_pkg::OFS_BOOT_CFG, {23'h0, c[0], c[3:0], c[1], c[2], c[1], ~c[0]});
      chk("o_root_freq_code", prev, code);
      chk("o_bus_holder_en", c[2], hold);
      chk("o_io_level_1v2", c[1], lvl);
      press(LP + 10);
      prev = (c > 9) ? 4'h0 : c[3:0];
      chk("o_root_freq_code", prev, code);
      chk("o_framer_synth_hz", HZ[prev], hz);
      chk("o_framer_synth_en", !c[1] && prev != 0, sen);
      chk("o_framer_primary", !c[0], prim);
      chk("o_framer_clk_ext", c[1], cext);
      chk("o_instance_value", c[0], inst);
      chk("reboot_pulses", 2 * (c + 1), n_rbt);
      rreg(abc_pkg::OFS_STATUS, {23'h0, 1'b0, 1'b1, c[0], prev, c[1], ~c[0]});
    end
    $display("test boot done");
    // wake only while paused; short press is no reboot
    paused <= 1'b1;
    press(10);
    chk("o_data_oe", 1, oe);
    repeat (100) @(posedge clk);
    paused <= 1'b0;
    press(10);
    chk("o_data_oe", 0, oe);
    chk("o_root_freq_code", prev, code);
    chk("reboot_pulses", 22, n_rbt);
    chk("o_data_out", 1, dout);
    $display("test wake done");
    for (int s = 0; s < 4; s++) begin
      x = xs(x);
      wreg(abc_pkg::OFS_AUDIO_CFG, {24'h0, s[1:0], x[1:0], s[1:0], s[1:0]});
      repeat (4) @(posedge clk);
      if (s > 0) chk("o_in_mclk_en", 0, ien);
      repeat (26) @(posedge clk);
      chk("o_in_mclk_en", (s == 3) ? 3'h4 : 3'h4 >> s, ien);
      chk("o_out_mclk_en", (s == 3) ? 3'h4 : 3'h4 >> s, oen);
      chk("o_mclk_buf_en", 2'h3, {ibuf, obuf});
      chk("o_out_from_bus_clk", s == 0 || s == 3, fbus);
      chk("o_rate_converter_en", x[1:0], {aspd, adsi});
      chk("o_stream_sel", s, sel);
      chk("o_stream_port_lo", 2 * s, plo);
    end
    $display("test sources done");
    gear <= 4'h5;
    repeat (4) @(posedge clk);
    chk("o_stream_ok", 0, sok);
    gear <= 4'h9;
    oref <= 4'h7;
    repeat (4) @(posedge clk);
    chk("o_synth_conflict", 1, conf);
    chk("o_out_mclk_en", 0, oen);
    chk("o_in_mclk_128fs", 0, f128);
    rate <= 8'hC0;
    repeat (4) @(posedge clk);
    chk("o_in_mclk_128fs", 1, f128);
    $display("test gears done");
    for (int i = 0; i < 3; i++) begin
      x = xs(x);
      vexp[8*i+:8] = x[7:0];
      wreg(abc_pkg::OFS_VALUE0 + 8'(4 * i), x);
      rreg(abc_pkg::OFS_VALUE0 + 8'(4 * i), {24'h0, x[7:0]});
    end
    chk("o_value_element", vexp, ve);
    $display("test values done");
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule : abc_clock_config_tb_top
`default_nettype wire
